// >>> spi_master_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module spi_master_fifo (
    input  wire logic                      CLK_IN,
    input  wire logic                      RST_B_IN,
    input  wire logic [7:0]                HOST_DATA_IN,
    output logic      [7:0]                HOST_DATA_OUT,
    input  wire logic                      HOST_READ_STROBE_IN,
    input  wire logic                      HOST_WRITE_STROBE_IN,
    input  wire logic                      HOST_SEL_CTRL_A_IN,
    input  wire logic                      HOST_SEL_CTRL_B_IN,
    input  wire logic                      HOST_SEL_DATA_IN,
    input  wire logic                      HOST_SEL_SPARE_IN,
    output logic                           HOST_IRQ_N_OUT,
    output logic                           TX_FULL_FLAG_OUT,
    output logic                           RX_EMPTY_FLAG_OUT,
    output logic                           RX_FULL_FLAG_OUT,
    output logic                           TRANSFER_DONE_FLAG_OUT,
    output logic                           SCK_OUT,
    output logic                           MOSI_OUT,
    input  wire logic                      MISO_IN,
    output logic      [spi_pkg::NUM_CS-1:0] SPI_CS_N_OUT
);

    spi_pkg::top_state_t q;
    spi_pkg::top_state_t d;

    logic       irq_enable;
    logic       shift_enable;
    logic       bit_order_sel;
    logic       master_select;
    logic       sck_idle_level;
    logic       sck_phase;
    logic [3:0] select_mask;
    logic [2:0] rate_select;

    logic       tx_push;
    logic       tx_pop;
    logic [7:0] tx_head;
    logic       tx_empty;
    logic       tx_full;
    logic       rx_push;
    logic       rx_pop;
    logic [7:0] rx_byte;
    logic [7:0] rx_head;
    logic       rx_empty;
    logic       rx_full;
    logic       presc_tick;
    logic       start_ok;
    logic       leading;
    logic       sample;
    logic [7:0] rx_word;
    logic [7:0] status;

    //==========================================================================
    // Helpers
    function automatic logic [spi_pkg::PRESC_W-1:0] rate_mask(input logic [2:0] r);
        rate_mask = spi_pkg::PRESC_FULL_MASK >> r;                         // [RQ15] [RQ16]
    endfunction

    function automatic logic [7:0] reverse8(input logic [7:0] v);
        for (int i = 0; i < 8; i++) begin
            reverse8[i] = v[7-i];
        end
    endfunction

    // Start of a byte: latch settings, pick first bit
    function automatic spi_pkg::top_state_t load_byte(input spi_pkg::top_state_t s,
                                                      input logic [7:0] b);
        load_byte         = s;
        load_byte.st      = spi_pkg::ST_SHIFT;
        load_byte.half    = 1'b0;
        load_byte.tx_byte = b;
        load_byte.order   = s.ctrl_a[spi_pkg::CA_ORDER_POS];
        load_byte.idle    = s.ctrl_a[spi_pkg::CA_IDLE_POS];
        load_byte.phase   = s.ctrl_a[spi_pkg::CA_PHASE_POS];
        load_byte.mask    = s.ctrl_b[spi_pkg::CB_MASK_LSB +: spi_pkg::NUM_CS];
        load_byte.cs_n    = load_byte.mask;                                // [RQ12] [RQ14]
        load_byte.idx     = load_byte.order ? spi_pkg::BIT_FIRST : spi_pkg::BIT_LAST;
        load_byte.bit_cnt = spi_pkg::BIT_FIRST;
        load_byte.mosi    = b[load_byte.idx];
        load_byte.sck     = load_byte.idle;
    endfunction

    //==========================================================================
    // Control fields
    assign irq_enable     = q.ctrl_a[spi_pkg::CA_IRQ_EN_POS];
    assign shift_enable   = q.ctrl_a[spi_pkg::CA_SHIFT_EN_POS];
    assign bit_order_sel  = q.ctrl_a[spi_pkg::CA_ORDER_POS];
    assign master_select  = q.ctrl_a[spi_pkg::CA_MASTER_POS];
    assign sck_idle_level = q.ctrl_a[spi_pkg::CA_IDLE_POS];
    assign sck_phase      = q.ctrl_a[spi_pkg::CA_PHASE_POS];
    assign select_mask    = q.ctrl_b[spi_pkg::CB_MASK_LSB +: spi_pkg::NUM_CS];
    assign rate_select    = q.ctrl_b[spi_pkg::CB_RATE_LSB +: spi_pkg::RATE_W];

    //==========================================================================
    // FIFOs
    assign tx_push = HOST_WRITE_STROBE_IN && HOST_SEL_DATA_IN;             // [RQ19]
    assign rx_pop  = HOST_READ_STROBE_IN && HOST_SEL_DATA_IN;              // [RQ19]

    spi_fifo tx_fifo (                                                     // [RQ6]
        .clk_in      (CLK_IN),
        .rst_b_in    (RST_B_IN),
        .wr_en_in    (tx_push),
        .wr_data_in  (HOST_DATA_IN),
        .rd_en_in    (tx_pop),
        .rd_data_out (tx_head),
        .empty_out   (tx_empty),
        .full_out    (tx_full)
    );

    spi_fifo rx_fifo (                                                     // [RQ6]
        .clk_in      (CLK_IN),
        .rst_b_in    (RST_B_IN),
        .wr_en_in    (rx_push),
        .wr_data_in  (rx_byte),
        .rd_en_in    (rx_pop),
        .rd_data_out (rx_head),
        .empty_out   (rx_empty),
        .full_out    (rx_full)
    );

    //==========================================================================
    // Status and interrupt
    assign TX_FULL_FLAG_OUT       = tx_full;                               // [RQ10]
    assign RX_EMPTY_FLAG_OUT      = rx_empty;                              // [RQ10]
    assign RX_FULL_FLAG_OUT       = rx_full;                               // [RQ10]
    assign TRANSFER_DONE_FLAG_OUT = tx_empty && (q.st == spi_pkg::ST_IDLE); // [RQ11]
    assign HOST_IRQ_N_OUT         = !(irq_enable && tx_empty);             // [RQ4] [RQ5]

    always_comb begin
        status = {5'h00, rate_select};
        status[spi_pkg::SB_DONE_POS]     = TRANSFER_DONE_FLAG_OUT;
        status[spi_pkg::SB_TX_FULL_POS]  = tx_full;
        status[spi_pkg::SB_RX_EMPTY_POS] = rx_empty;
        status[spi_pkg::SB_RX_FULL_POS]  = rx_full;
    end

    //==========================================================================
    // Host data and serial outputs
    assign HOST_DATA_OUT = q.host_dout;
    assign SCK_OUT       = q.sck;
    assign MOSI_OUT      = q.mosi;
    assign SPI_CS_N_OUT  = q.cs_n;

    assign start_ok = shift_enable && master_select && !tx_empty;          // [RQ1] [RQ3]
    assign leading  = !q.half;
    assign sample   = (leading ^ q.phase) && (q.st == spi_pkg::ST_SHIFT);  // [RQ17]
    assign rx_word  = {q.rx_sr[6:0], MISO_IN};
    assign rx_byte  = q.order ? reverse8(rx_word) : rx_word;               // [RQ2] [RQ23]

    //==========================================================================
    // Next state
    always_comb begin
        d      = q;
        tx_pop = 1'b0;
        // Carry out of the ORed counter is the FSM enable
        {presc_tick, d.presc} = 8'({1'b0, q.presc | rate_mask(rate_select)}) + 8'h01; // [RQ21]

        // Host side; host_sel_spare plays no part
        if (HOST_WRITE_STROBE_IN) begin                                    // [RQ18]
            if (HOST_SEL_CTRL_A_IN) begin
                d.ctrl_a = HOST_DATA_IN;
            end else if (HOST_SEL_CTRL_B_IN) begin
                d.ctrl_b = HOST_DATA_IN;
            end
        end
        if (HOST_READ_STROBE_IN) begin                                     // [RQ18]
            if (HOST_SEL_CTRL_A_IN) begin
                d.host_dout = q.ctrl_a & spi_pkg::CA_RD_MASK;
            end else if (HOST_SEL_CTRL_B_IN) begin
                d.host_dout = status;
            end else if (HOST_SEL_DATA_IN) begin
                d.host_dout = rx_head;                                     // [RQ19]
            end
        end

        if (presc_tick) begin                                              // [RQ21]
            unique case (q.st)
                spi_pkg::ST_IDLE: begin
                    d.sck  = sck_idle_level;
                    d.cs_n = spi_pkg::CS_ALL_OFF;
                    if (start_ok) begin                                    // [RQ22]
                        d      = load_byte(d, tx_head);
                        tx_pop = 1'b1;
                    end
                end
                spi_pkg::ST_SHIFT: begin
                    d.half = !q.half;
                    d.sck  = !q.sck;                                       // [RQ24]
                    if (sample) begin
                        d.rx_sr = rx_word;                                 // [RQ23]
                    end
                    if (leading) begin
                        if (q.phase) begin
                            d.mosi = q.tx_byte[q.idx];                     // [RQ17]
                        end
                    end else begin
                        d.idx     = q.order ? q.idx + 3'h1 : q.idx - 3'h1; // [RQ2] [RQ22]
                        d.bit_cnt = q.bit_cnt + 3'h1;
                        if (!q.phase) begin
                            d.mosi = q.tx_byte[d.idx];
                        end
                        if (q.bit_cnt == spi_pkg::BIT_LAST) begin          // [RQ26]
                            if (start_ok) begin
                                d      = load_byte(d, tx_head);
                                d.cs_n = q.cs_n;                           // [RQ26]
                                d.mask = q.mask;
                                tx_pop = 1'b1;
                            end else begin
                                d.st = spi_pkg::ST_TAIL;
                            end
                        end
                    end
                end
                spi_pkg::ST_TAIL: begin
                    d.cs_n = spi_pkg::CS_ALL_OFF;                          // [RQ26]
                    d.st   = spi_pkg::ST_IDLE;
                end
                default: begin
                    d.st   = spi_pkg::ST_IDLE;
                    d.cs_n = spi_pkg::CS_ALL_OFF;
                end
            endcase
        end
    end

    assign rx_push = presc_tick && sample && (q.bit_cnt == spi_pkg::BIT_LAST); // [RQ23]

    //==========================================================================
    // State register
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin                                               // [RQ20]
            q        <= '0;
            q.ctrl_a <= spi_pkg::CTRL_A_RST;
            q.ctrl_b <= spi_pkg::CTRL_B_RST;
            q.mask   <= spi_pkg::CS_ALL_OFF;
            q.cs_n   <= spi_pkg::CS_ALL_OFF;
        end else begin
            q <= d;
        end
    end

    //==========================================================================
    // Checks
    irq_level_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // [RQ4]
        (!HOST_IRQ_N_OUT) == (irq_enable && tx_empty))
        else $error("interrupt does not follow enable and TX empty");
    cs_idle_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // [RQ14]
        (q.st == spi_pkg::ST_IDLE) |-> (SPI_CS_N_OUT == spi_pkg::CS_ALL_OFF))
        else $error("chip select active while idle");
    cs_mask_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // [RQ12]
        (q.st == spi_pkg::ST_SHIFT) |-> (SPI_CS_N_OUT == q.mask))
        else $error("chip selects differ from latched mask");
    no_start_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // [RQ3]
        (q.st == spi_pkg::ST_IDLE) && !(shift_enable && master_select)
        |=> (q.st == spi_pkg::ST_IDLE))
        else $error("transfer began while disabled");
    tick_gate_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // [RQ21]
        !presc_tick |=> $stable(q.st) && $stable(q.sck) && $stable(q.bit_cnt))
        else $error("FSM moved without prescaler enable");
    fast_rate_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // [RQ15]
        (rate_select == 3'h0) |-> presc_tick)
        else $error("fastest rate missed an enable");
    sck_idle_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // [RQ17]
        (q.st == spi_pkg::ST_IDLE) && $past(q.st == spi_pkg::ST_IDLE)
        && $past(presc_tick) |-> (SCK_OUT == $past(sck_idle_level)))
        else $error("SCK not at idle level");
    byte_len_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // [RQ26]
        tx_pop ##1 (!tx_pop)[*1] |-> (q.bit_cnt == spi_pkg::BIT_FIRST))
        else $error("byte did not start at bit zero");
    rx_push_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN) // [RQ23]
        rx_push && !rx_full |=> !rx_empty)
        else $error("received byte not written to receive FIFO");

    burst_c: cover property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        (q.st == spi_pkg::ST_SHIFT) && tx_pop);
    lsb_c: cover property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        rx_push && q.order && q.phase);
    tx_full_c: cover property (@(posedge CLK_IN) disable iff (!RST_B_IN)
        tx_full && tx_push);

endmodule
`default_nettype wire

// >>> spi_pkg.sv
//==============================================================================
// Notes on behaviour
// RQ1 - Transfers start only with master_select at 1; slave mode is not built.
// RQ2 - bit_order_sel 0 shifts MSB first, 1 shifts LSB first, both directions.
// RQ3 - shift_enable 0 keeps the shifter idle; 1 shifts while TX data waits.
// RQ4 - With irq_enable 1 the interrupt is asserted while TX FIFO is empty.
// RQ5 - host_irq_n is active low.
// RQ6 - Separate 32-byte FIFOs for transmit and receive.
// RQ7 - Each FIFO is 32 by 8 with 6-bit read and write pointers.
// RQ8 - Empty when pointers match in low five bits and in top bit.
// RQ9 - Full when low five bits match and top bits differ.
// RQ10 - Host reads tx_full_flag, rx_empty_flag, rx_full_flag, each 1 while true.
// RQ11 - transfer_done_flag reads 1 once the transmit FIFO has been emptied; here it also needs the FSM back in ST_IDLE.
// RQ12 - A select_mask bit at 0 enables its chip select during a transfer.
// RQ13 - Software should select only one peripheral at a time.
// RQ14 - Up to four active-low chip selects driven without host action.
// RQ15 - Bit rate is the system clock prescaled by 2 up to 256.
// RQ16 - Three-bit rate_select picks the programmable bit rate.
// RQ17 - sck_idle_level and sck_phase follow standard SPI mode conventions.
// RQ18 - Selects: ctrl_a, ctrl_b, data; host_sel_spare is ignored.
// RQ19 - Data write pushes TX FIFO; data read pops RX FIFO.
// RQ20 - Reset by sys_reset_n, active low.
// RQ21 - FSM updates only on prescaler carry, counter ORed with rate mask.
// RQ22 - Non-empty TX FIFO: capture settings, shift byte via stepping bit index.
// RQ23 - Receiver shifts MISO at transmitter rate; eight bits written to RX FIFO.
// RQ24 - Transmitter FSM makes SCK and enables chip selects and sampling.
// RQ25 - Writes when TX full dropped; reads when RX empty keep pointer.
// RQ26 - Eight bits per byte; select held across burst, released when drained.
package spi_pkg;

    //==========================================================================
    // Sizes
    localparam int DATA_W  = 8;
    localparam int ADDR_W  = 5;
    localparam int PTR_W   = 6;
    localparam int DEPTH   = 32;
    localparam int NUM_CS  = 4;
    localparam int RATE_W  = 3;
    localparam int PRESC_W = 7;

    localparam logic [PRESC_W-1:0] PRESC_FULL_MASK = 7'h7F;

    //==========================================================================
    // Control A fields
    localparam int CA_IRQ_EN_POS   = 7;
    localparam int CA_SHIFT_EN_POS = 6;
    localparam int CA_ORDER_POS    = 5;
    localparam int CA_MASTER_POS   = 4;
    localparam int CA_IDLE_POS     = 3;
    localparam int CA_PHASE_POS    = 2;
    localparam logic [7:0] CA_RD_MASK  = 8'hFC;
    localparam logic [7:0] CTRL_A_RST  = 8'h10;

    //==========================================================================
    // Control B fields, status on read
    localparam int CB_MASK_LSB    = 4;
    localparam int CB_RATE_LSB    = 0;
    localparam int SB_DONE_POS    = 7;
    localparam int SB_TX_FULL_POS = 6;
    localparam int SB_RX_EMPTY_POS = 5;
    localparam int SB_RX_FULL_POS = 4;
    localparam logic [7:0] CTRL_B_RST = 8'hF7;

    localparam logic [NUM_CS-1:0] CS_ALL_OFF = 4'hF;
    localparam logic [2:0]        BIT_LAST   = 3'h7;
    localparam logic [2:0]        BIT_FIRST  = 3'h0;

    //==========================================================================
    // Types
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_TAIL  = 2'b10
    } tx_state_t;

    typedef struct packed {
        logic [PTR_W-1:0]  wr_ptr;
        logic [PTR_W-1:0]  rd_ptr;
        logic [DATA_W-1:0] rd_data;
    } fifo_state_t;

    typedef struct packed {
        logic [7:0]         ctrl_a;
        logic [7:0]         ctrl_b;
        logic [7:0]         host_dout;
        logic [PRESC_W-1:0] presc;
        tx_state_t          st;
        logic               half;
        logic [2:0]         idx;
        logic [2:0]         bit_cnt;
        logic [7:0]         tx_byte;
        logic [7:0]         rx_sr;
        logic               order;
        logic               idle;
        logic               phase;
        logic [NUM_CS-1:0]  mask;
        logic               sck;
        logic               mosi;
        logic [NUM_CS-1:0]  cs_n;
    } top_state_t;

endpackage

// >>> spi_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module spi_fifo (
    input  wire logic                      clk_in,
    input  wire logic                      rst_b_in,
    input  wire logic                      wr_en_in,
    input  wire logic [spi_pkg::DATA_W-1:0] wr_data_in,
    input  wire logic                      rd_en_in,
    output logic      [spi_pkg::DATA_W-1:0] rd_data_out,
    output logic                           empty_out,
    output logic                           full_out
);

    spi_pkg::fifo_state_t q;
    spi_pkg::fifo_state_t d;
    logic [spi_pkg::DATA_W-1:0] mem [spi_pkg::DEPTH];
    logic                       push;
    logic                       pop;

    //==========================================================================
    // Flags from extended pointers
    assign empty_out = (q.wr_ptr == q.rd_ptr);                            // [RQ8]
    assign full_out  = (q.wr_ptr[spi_pkg::ADDR_W-1:0] == q.rd_ptr[spi_pkg::ADDR_W-1:0])
                     && (q.wr_ptr[spi_pkg::ADDR_W] != q.rd_ptr[spi_pkg::ADDR_W]); // [RQ9]
    assign rd_data_out = q.rd_data;

    always_comb begin
        d    = q;
        push = wr_en_in && !full_out;                                      // [RQ25]
        pop  = rd_en_in && !empty_out;                                     // [RQ25]
        d.wr_ptr = q.wr_ptr + spi_pkg::PTR_W'(push);                       // [RQ7]
        d.rd_ptr = q.rd_ptr + spi_pkg::PTR_W'(pop);
        // Bypass so a word written to the head shows up at once
        if (push && (q.wr_ptr[spi_pkg::ADDR_W-1:0] == d.rd_ptr[spi_pkg::ADDR_W-1:0])) begin
            d.rd_data = wr_data_in;
        end else begin
            d.rd_data = mem[d.rd_ptr[spi_pkg::ADDR_W-1:0]];
        end
    end

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[q.wr_ptr[spi_pkg::ADDR_W-1:0]] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    //==========================================================================
    // Checks
    full_hold_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ25]
        full_out && wr_en_in && !rd_en_in |=> full_out && $stable(q.wr_ptr))
        else $error("write into full FIFO moved pointer");
    empty_hold_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ8]
        empty_out && rd_en_in && !wr_en_in |=> empty_out && $stable(q.rd_ptr))
        else $error("read of empty FIFO moved pointer");
    fill_state_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ9]
        wr_en_in && !rd_en_in && empty_out |=> !empty_out && !full_out)
        else $error("single write into empty FIFO gave wrong flags");

endmodule
`default_nettype wire

// >>> spi_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
//==============================================================================
// Peripheral on the serial link
module spi_slave_model (
    input  wire logic       clk_in,
    input  wire logic       sck_in,
    input  wire logic       mosi_in,
    input  wire logic [3:0] cs_n_in,
    input  wire logic       idle_in,
    input  wire logic       phase_in,
    input  wire logic       order_in,
    input  wire logic [7:0] reply_in,
    output logic            miso_out
);
    logic [2:0] n = 3'h0;
    logic [7:0] sr = 8'h00;
    logic [7:0] got_q = 8'h00;
    logic [7:0] nrx = 8'h00;
    logic       sck_q = 1'b0;
    logic       sel_q = 1'b0;
    logic       sel;
    logic [2:0] bi;
    logic [7:0] tx;
    initial miso_out = 1'b0;
    // Released line toggles so stale data never passes
    always @(posedge clk_in) begin
        if (cs_n_in === 4'hF) begin
            miso_out <= ~miso_out;
        end
    end
    always @(cs_n_in or sck_in) begin
        #1;
        sel = (cs_n_in !== 4'hF);
        bi = order_in ? n : 3'h7 - n;
        tx = reply_in ^ nrx;
        if (sel && !sel_q) begin
            if (!phase_in) begin
                miso_out = tx[bi];
            end
        end else if (sel && sck_in !== sck_q) begin
            if ((sck_in !== idle_in) ^ phase_in) begin
                sr[bi] = mosi_in;
                n = n + 3'h1;
                if (n == 3'h0) begin
                    got_q = sr;
                    nrx = nrx + 8'h01;
                end
            end else begin
                miso_out = tx[bi];
            end
        end
        sck_q = sck_in;
        sel_q = sel;
    end
endmodule
`default_nettype wire

// >>> spi_master_fifo_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
//==============================================================================
// Bench
module spi_master_fifo_tb_top;
    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       rd = 1'b0;
    logic       wr = 1'b0;
    logic       idle = 1'b0;
    logic       phase = 1'b0;
    logic       order = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [3:0] cs_n;
    logic [3:0] cs_last = 4'hF;
    logic [7:0] din = 8'h00;
    logic [7:0] dout;
    logic [7:0] reply = 8'h9E;
    logic       irq_n, tx_full_flag, rx_empty_flag, rx_full_flag, done, sck, mosi, miso;
    int         n_errors = 0;
    int         comparisons = 0;
    int         cycles = 0;
    int         cs_cnt = 0;
    spi_master_fifo spi_master_fifo_i (.CLK_IN(clk), .RST_B_IN(rst_b), .HOST_DATA_IN(din),
        .HOST_DATA_OUT(dout), .HOST_READ_STROBE_IN(rd), .HOST_WRITE_STROBE_IN(wr),
        .HOST_SEL_CTRL_A_IN(sel[0]), .HOST_SEL_CTRL_B_IN(sel[1]), .HOST_SEL_DATA_IN(sel[2]),
        .HOST_SEL_SPARE_IN(sel[3]), .HOST_IRQ_N_OUT(irq_n), .TX_FULL_FLAG_OUT(tx_full_flag),
        .RX_EMPTY_FLAG_OUT(rx_empty_flag), .RX_FULL_FLAG_OUT(rx_full_flag), .TRANSFER_DONE_FLAG_OUT(done),
        .SCK_OUT(sck), .MOSI_OUT(mosi), .MISO_IN(miso), .SPI_CS_N_OUT(cs_n));
    spi_slave_model spi_slave_model_i (.clk_in(clk), .sck_in(sck), .mosi_in(mosi),
        .cs_n_in(cs_n), .idle_in(idle), .phase_in(phase), .order_in(order),
        .reply_in(reply), .miso_out(miso));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic host(input logic [3:0] s, input logic w, input logic [7:0] d);
        sel <= s;
        wr <= w;
        rd <= !w;
        din <= d;
        @(posedge clk);
        sel <= 4'h0;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic cfg(input logic [7:0] a, input logic [7:0] b);
        host(4'h1, 1'b1, a);
        host(4'h2, 1'b1, b);
        idle = a[3];
        phase = a[2];
        order = a[5];
    endtask
    task automatic wait_done;
        for (int k = 0; k < 4000 && done !== 1'b1; k++) @(posedge clk);
        chk("done", 8'h01, {7'h0, done});
    endtask
    task automatic t_reset;
        chk("irq_n", 8'h01, {7'h0, irq_n});
        host(4'h1, 1'b0, 8'h00);
        chk("ctrl_a", 8'h10, dout);
        host(4'h2, 1'b0, 8'h00);
        chk("status", 8'hA7, dout);
        host(4'h8, 1'b1, 8'hFF);
        host(4'h1, 1'b0, 8'h00);
        chk("spare", 8'h10, dout);
    endtask
    task automatic t_modes;
        logic [7:0] d;
        for (int i = 0; i < 8; i++) begin
            d = 8'h35 + 8'(i * 29);
            cfg({2'b01, i[2], 1'b1, i[1:0], 2'b00}, {~(4'h1 << i[1:0]), 4'h1});
            host(4'h4, 1'b1, d);
            wait_done();
            chk("mosi byte", d, spi_slave_model_i.got_q);
            chk("cs", {4'h0, ~(4'h1 << i[1:0])}, {4'h0, cs_last});
            chk("sck idle", {7'h0, i[1]}, {7'h0, sck});
            host(4'h4, 1'b0, 8'h00);
            chk("miso byte", reply ^ 8'(i), dout);
        end
    endtask
    task automatic t_ctl;
        int c;
        cfg(8'h90, 8'hE1);
        chk("irq empty", 8'h00, {7'h0, irq_n});
        c = cs_cnt;
        host(4'h4, 1'b1, 8'h6A);
        chk("irq data", 8'h01, {7'h0, irq_n});
        cfg(8'hC0, 8'hE1);
        repeat (40) @(posedge clk);
        chk("no frame", c[7:0], cs_cnt[7:0]);
        cfg(8'h50, 8'hE1);
        wait_done();
        chk("frame", 8'h6A, spi_slave_model_i.got_q);
        host(4'h4, 1'b0, 8'h00);
    endtask
    task automatic t_fill;
        logic [7:0] n0;
        cfg(8'h10, 8'hB0);
        n0 = spi_slave_model_i.nrx;
        for (int i = 0; i < 33; i++) host(4'h4, 1'b1, (i == 32) ? 8'hEE : 8'(i));
        chk("tx full", 8'h01, {7'h0, tx_full_flag});
        cfg(8'h50, 8'hB0);
        wait_done();
        chk("count", n0 + 8'h20, spi_slave_model_i.nrx);
        chk("last", 8'h1F, spi_slave_model_i.got_q);
        chk("rx full", 8'h01, {7'h0, rx_full_flag});
        for (int i = 0; i < 32; i++) begin
            host(4'h4, 1'b0, 8'h00);
            chk("rx", reply ^ (n0 + 8'(i)), dout);
        end
        chk("rx empty", 8'h01, {7'h0, rx_empty_flag});
    endtask
    task automatic t_rate;
        int p;
        for (int r = 0; r < 8; r = r * 2 + 1) begin
            cfg(8'h50, {4'hE, 1'b0, 3'(r)});
            host(4'h4, 1'b1, 8'hC3);
            for (int k = 0; k < 600 && !sck; k++) @(posedge clk);
            for (int k = 0; k < 600 && sck; k++) @(posedge clk);
            for (p = 0; p < 600 && !sck; p++) @(posedge clk);
            chk("half bit", 8'(1 << r), 8'(p));
            wait_done();
            host(4'h4, 1'b0, 8'h00);
        end
    endtask
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cs_n !== 4'hF) begin
            cs_cnt++;
            cs_last = cs_n;
        end
        if (cycles == 30000) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_reset();
        $display("test reset ended");
        t_modes();
        $display("test modes ended");
        t_ctl();
        $display("test control ended");
        t_fill();
        $display("test fill ended");
        t_rate();
        $display("test rate ended");
        end_of_test();
    end
endmodule
`default_nettype wire
